// >>> companion_slave.sv
// two-target serial slave with calibration and trickle-charge controls
`timescale 1ns/100ps

module companion_slave
    import companion_pkg::*;
#(
    parameter int unsigned CAL_HALF_CYCLES = CAL_HALF_CYC
) (
    // system clock domain
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    // link sampling clock domain
    input  wire logic       link_clk_i,
    // serial bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // device select straps and supply monitor
    input  wire logic [1:0] dev_sel_i,
    input  wire logic       supply_low_i,
    // analog companion interface
    input  wire logic       powerfail_compare_i,
    output logic            calib_or_powerfail_out_o,
    output logic            backup_charge_enable_o,
    output logic            fast_charge_select_o
);

    // ------------------------------------------------------------
    // reset into the link domain
    // ------------------------------------------------------------
    logic link_rst_m_reg;
    logic link_rst_reg;
    always_ff @(posedge link_clk_i) begin
        link_rst_m_reg <= sys_rst_i;
        link_rst_reg   <= link_rst_m_reg;
    end

    // ------------------------------------------------------------
    // pin sampling: a change counts once stages two and three agree
    // ------------------------------------------------------------
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [4:0] pin_reg;
    logic       scl_prev_reg;
    logic       sda_prev_reg;
    always_ff @(posedge link_clk_i) begin
        pin_s1_reg <= {supply_low_i, dev_sel_i, sda_i, scl_i};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
    end

    always_ff @(posedge link_clk_i) begin
        if (link_rst_reg) begin
            pin_reg      <= 5'h0_003;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            pin_reg      <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
            scl_prev_reg <= pin_reg[0];
            sda_prev_reg <= pin_reg[1];
        end
    end

    logic       scl_q;
    logic       sda_q;
    logic [1:0] sel_q;
    logic       supply_low_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    assign scl_q        = pin_reg[0];
    assign sda_q        = pin_reg[1];
    assign sel_q        = pin_reg[3:2];
    assign supply_low_q = pin_reg[4];
    assign scl_rise     = scl_q && !scl_prev_reg;
    assign scl_fall     = !scl_q && scl_prev_reg;
    assign start_seen   = scl_q && scl_prev_reg && sda_prev_reg && !sda_q;
    assign stop_seen    = scl_q && scl_prev_reg && !sda_prev_reg && sda_q;

    // ------------------------------------------------------------
    // bus engine
    // ------------------------------------------------------------
    bus_state_t st_reg;
    logic [7:0] sh_reg;
    logic [3:0] cnt_reg;
    logic       oe_reg;
    logic       comp_reg;
    logic       after_sub_reg;
    logic       mack_reg;
    logic [1:0] mab_reg;
    logic [4:0] ptr_reg;
    logic [7:0] regs_reg [0:NUM_REGS-1];
    logic       wr_stb;
    logic [7:0] rd_byte;
    function automatic logic [4:0] next_ptr(input logic [4:0] p);
        next_ptr = (p == REG_LAST[4:0]) ? REG_CTRL : p + 5'h0_001;
    endfunction : next_ptr
    function automatic logic addr_match(input logic [7:0] b, input logic [1:0] sel);
        addr_match = ((b[ADDR_ID_HI:ADDR_ID_LO] == ID_MEMORY) ||
                      (b[ADDR_ID_HI:ADDR_ID_LO] == ID_COMPANION)) &&
                     (b[ADDR_SEL_HI:ADDR_SEL_LO] == sel);
    endfunction : addr_match
    // memory array datapath lives elsewhere; reads return a fixed byte
    assign rd_byte = comp_reg ? regs_reg[ptr_reg] : MEM_IDLE_DATA;
    assign wr_stb  = scl_fall && (st_reg == ST_WDATA) &&
                     (cnt_reg == BITS_PER_BYTE) && comp_reg && !supply_low_q;

    always_ff @(posedge link_clk_i) begin
        if (link_rst_reg || stop_seen || supply_low_q) begin
            st_reg        <= ST_IDLE;
            oe_reg        <= 1'b0;
            cnt_reg       <= '0;
            sh_reg        <= '0;
            comp_reg      <= 1'b0;
            after_sub_reg <= 1'b0;
            mack_reg      <= 1'b0;
            mab_reg       <= '0;
            if (link_rst_reg) begin
                ptr_reg <= REG_CTRL;
            end
        end else if (start_seen) begin
            st_reg  <= ST_ADDR;
            oe_reg  <= 1'b0;
            cnt_reg <= '0;
        end else if (scl_rise) begin
            if (st_reg == ST_ADDR || st_reg == ST_SUB || st_reg == ST_WDATA) begin
                sh_reg  <= {sh_reg[6:0], sda_q};
                cnt_reg <= cnt_reg + 4'h0_001;
            end else if (st_reg == ST_ACK_OUT) begin
                mack_reg <= !sda_q;
            end
        end else if (scl_fall) begin
            case (st_reg)
                ST_ADDR: begin
                    if (cnt_reg == BITS_PER_BYTE) begin
                        if (addr_match(sh_reg, sel_q)) begin
                            st_reg        <= ST_ACK_IN;
                            oe_reg        <= 1'b1;
                            comp_reg      <= (sh_reg[ADDR_ID_HI:ADDR_ID_LO] == ID_COMPANION);
                            mack_reg      <= sh_reg[ADDR_RW_BIT];
                            after_sub_reg <= 1'b0;
                            mab_reg       <= '0;
                        end else begin
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_IN: begin
                    cnt_reg <= '0;
                    if (mack_reg && !after_sub_reg) begin
                        st_reg  <= ST_RDATA;
                        sh_reg  <= rd_byte;
                        oe_reg  <= !rd_byte[7];
                        cnt_reg <= 4'h0_001;
                    end else if (!after_sub_reg ||
                                 (!comp_reg && mab_reg != MEM_ADDR_BYTES)) begin
                        st_reg <= ST_SUB;
                        oe_reg <= 1'b0;
                    end else begin
                        st_reg <= ST_WDATA;
                        oe_reg <= 1'b0;
                    end
                    mack_reg <= 1'b0;
                end
                ST_SUB: begin
                    if (cnt_reg == BITS_PER_BYTE) begin
                        after_sub_reg <= 1'b1;
                        if (comp_reg && sh_reg > REG_LAST) begin
                            st_reg <= ST_IDLE;
                        end else begin
                            if (comp_reg) begin
                                ptr_reg <= sh_reg[4:0];
                            end
                            mab_reg <= mab_reg + 2'h0_001;
                            st_reg  <= ST_ACK_IN;
                            oe_reg  <= 1'b1;
                        end
                    end
                end
                ST_WDATA: begin
                    if (cnt_reg == BITS_PER_BYTE) begin
                        st_reg <= ST_ACK_IN;
                        oe_reg <= 1'b1;
                        if (comp_reg) begin
                            ptr_reg <= next_ptr(ptr_reg);
                        end
                    end
                end
                ST_RDATA: begin
                    if (cnt_reg == BITS_PER_BYTE) begin
                        st_reg <= ST_ACK_OUT;
                        oe_reg <= 1'b0;
                        if (comp_reg) begin
                            ptr_reg <= next_ptr(ptr_reg);
                        end
                    end else begin
                        sh_reg  <= {sh_reg[6:0], 1'b0};
                        oe_reg  <= !sh_reg[6];
                        cnt_reg <= cnt_reg + 4'h0_001;
                    end
                end
                ST_ACK_OUT: begin
                    if (mack_reg) begin
                        st_reg  <= ST_RDATA;
                        sh_reg  <= rd_byte;
                        oe_reg  <= !rd_byte[7];
                        cnt_reg <= 4'h0_001;
                    end else begin
                        st_reg <= ST_IDLE;
                    end
                    mack_reg <= 1'b0;
                end
                default: begin
                    st_reg <= ST_IDLE;
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // open-drain: only ever pulls low; clock line has no driver here
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_reg;

    // ------------------------------------------------------------
    // companion register file
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (link_rst_reg) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_reg[i] <= REG_RESET;
            end
        end else if (wr_stb) begin
            if (ptr_reg == REG_CORR) begin
                if (regs_reg[REG_CTRL][CAL_MODE_BIT]) begin
                    regs_reg[REG_CORR] <= sh_reg;
                end
            end else begin
                regs_reg[ptr_reg] <= sh_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // control levels into the system domain
    // ------------------------------------------------------------
    logic [8:0] ctl_link;
    logic [8:0] ctl_s1_reg;
    logic [8:0] ctl_s2_reg;
    logic [8:0] ctl_s3_reg;
    logic [8:0] ctl_reg;
    logic [2:0] pf_sync_reg;
    logic       pf_ok_reg;
    assign ctl_link = {regs_reg[REG_CORR][CORR_SIGN_BIT],
                       regs_reg[REG_CORR][CORR_MAG_HI:CORR_MAG_LO],
                       regs_reg[REG_CHARGE][FC_BIT],
                       regs_reg[REG_CHARGE][VBC_BIT],
                       regs_reg[REG_CTRL][CAL_MODE_BIT]};

    // whole word taken only once two stages agree, so a write never lands half-seen
    always_ff @(posedge mclk_i) begin
        ctl_s1_reg <= ctl_link;
        ctl_s2_reg <= ctl_s1_reg;
        ctl_s3_reg <= ctl_s2_reg;
        if (sys_rst_i) begin
            ctl_reg <= '0;
        end else if (ctl_s2_reg == ctl_s3_reg) begin
            ctl_reg <= ctl_s3_reg;
        end
    end

    logic       cal_mode;
    logic       corr_sign;
    logic [4:0] corr_mag;
    assign cal_mode  = ctl_reg[0];
    assign corr_mag  = ctl_reg[7:3];
    assign corr_sign = ctl_reg[8];
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            backup_charge_enable_o <= 1'b0;
            fast_charge_select_o   <= 1'b0;
        end else begin
            backup_charge_enable_o <= ctl_reg[1];
            fast_charge_select_o   <= ctl_reg[2];
        end
    end

    always_ff @(posedge mclk_i) begin
        pf_sync_reg <= {pf_sync_reg[1:0], powerfail_compare_i};
        if (sys_rst_i) begin
            pf_ok_reg <= 1'b1;
        end else if (pf_sync_reg[1] == pf_sync_reg[2]) begin
            pf_ok_reg <= pf_sync_reg[2];
        end
    end

    // ------------------------------------------------------------
    // calibration square wave with pulse correction
    // ------------------------------------------------------------
    logic [31:0] half_cnt_reg;
    logic [6:0]  halves_reg;
    logic        sq_reg;
    logic [31:0] reload;
    // once per correction window one half-period is stretched or shortened
    always_comb begin
        reload = CAL_HALF_CYCLES - 32'h0_001;
        if (halves_reg == 7'(CORR_HALVES - 1)) begin
            reload = corr_sign ? reload - 32'(corr_mag) : reload + 32'(corr_mag);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !cal_mode) begin
            half_cnt_reg <= CAL_HALF_CYCLES - 32'h0_001;
            halves_reg   <= '0;
            sq_reg       <= 1'b0;
        end else if (half_cnt_reg == 32'h0_000) begin
            half_cnt_reg <= reload;
            sq_reg       <= !sq_reg;
            halves_reg   <= (halves_reg == 7'(CORR_HALVES - 1)) ? 7'h0_000
                                                                 : halves_reg + 7'h0_001;
        end else begin
            half_cnt_reg <= half_cnt_reg - 32'h0_001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            calib_or_powerfail_out_o <= 1'b1;
        end else if (cal_mode) begin
            calib_or_powerfail_out_o <= sq_reg;
        end else begin
            calib_or_powerfail_out_o <= pf_ok_reg;
        end
    end

endmodule : companion_slave

// >>> companion_pkg.sv
// constants for the two-target serial slave and companion controls
package companion_pkg;

    // ------------------------------------------------------------
    // clocks and timing
    // ------------------------------------------------------------
    localparam int unsigned MCLK_HZ      = 25_000_000;
    localparam int unsigned CAL_FREQ_HZ  = 512;
    localparam int unsigned CAL_HALF_CYC = MCLK_HZ / (2 * CAL_FREQ_HZ);
    localparam int unsigned CORR_HALVES  = 64;

    // ------------------------------------------------------------
    // slave address decode
    // ------------------------------------------------------------
    localparam logic [3:0] ID_MEMORY    = 4'h0_00A;
    localparam logic [3:0] ID_COMPANION = 4'h0_00D;
    localparam int unsigned ADDR_ID_HI  = 7;
    localparam int unsigned ADDR_ID_LO  = 4;
    localparam int unsigned ADDR_SEL_HI = 2;
    localparam int unsigned ADDR_SEL_LO = 1;
    localparam int unsigned ADDR_RW_BIT = 0;

    // ------------------------------------------------------------
    // companion register space
    // ------------------------------------------------------------
    localparam int unsigned NUM_REGS     = 25;
    localparam logic [7:0]  REG_LAST     = 8'h0_018;
    localparam logic [4:0]  REG_CTRL     = 5'h0_000;
    localparam logic [4:0]  REG_CORR     = 5'h0_001;
    localparam logic [4:0]  REG_CHARGE   = 5'h0_00B;
    localparam int unsigned CAL_MODE_BIT = 2;
    localparam int unsigned CORR_MAG_HI  = 4;
    localparam int unsigned CORR_MAG_LO  = 0;
    localparam int unsigned CORR_SIGN_BIT = 5;
    localparam int unsigned VBC_BIT      = 2;
    localparam int unsigned FC_BIT       = 5;
    localparam logic [7:0]  REG_RESET    = 8'h0_000;
    localparam logic [7:0]  MEM_IDLE_DATA = 8'h0_0FF;

    // ------------------------------------------------------------
    // bus engine
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h0_008;
    localparam logic [1:0] MEM_ADDR_BYTES = 2'h0_002;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_ACK_IN  = 3'b010,
        ST_SUB     = 3'b011,
        ST_WDATA   = 3'b100,
        ST_RDATA   = 3'b101,
        ST_ACK_OUT = 3'b110
    } bus_state_t;

endpackage : companion_pkg

// >>> companion_slave_sva.sv
// port-level assertions for the two-target serial slave
`timescale 1ns/100ps
module companion_slave_sva
    import companion_pkg::*;
#(
    parameter int unsigned CAL_HALF_CYCLES = CAL_HALF_CYC
) (
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    input wire logic       link_clk_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [1:0] dev_sel_i,
    input wire logic       supply_low_i,
    input wire logic       powerfail_compare_i,
    input wire logic       calib_or_powerfail_out_o,
    input wire logic       backup_charge_enable_o,
    input wire logic       fast_charge_select_o
);
    // ----------------------------------------
    // helper: cycles since the device last pulled the data line
    // ----------------------------------------
    int unsigned since_ack;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || sda_oe_o) begin
            since_ack <= 0;
        end else if (since_ack < 1000) begin
            since_ack <= since_ack + 1;
        end
    end

    sequence s_start;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence

    chk_reset_outputs: assert property (@(posedge mclk_i) sys_rst_i |=> // RESET
        !backup_charge_enable_o && !fast_charge_select_o && calib_or_powerfail_out_o)
        else $error("outputs not at reset level");
    chk_open_drain_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        sda_oe_o |-> sda_o == 1'b0) else $error("data pin driven high");
    chk_stop_idles: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        s_stop |=> !sda_oe_o [*8]) else $error("bus driven after stop");
    chk_start_aborts: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        s_start |=> !sda_oe_o [*8]) else $error("bus driven after start");
    chk_supply_aborts: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        supply_low_i [*6] |-> !sda_oe_o) else $error("bus driven while supply low");
    chk_oe_rise_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(sda_oe_o) |-> !scl_i) else $error("data changed while clock high");
    chk_oe_stands: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(sda_oe_o) && !supply_low_i |=> sda_oe_o [*6])
        else $error("data pull released early");
    chk_charge_after_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $changed(backup_charge_enable_o) || $changed(fast_charge_select_o) |->
        since_ack < 100) else $error("charger changed without a write");
endmodule : companion_slave_sva

bind companion_slave companion_slave_sva #(.CAL_HALF_CYCLES(CAL_HALF_CYCLES)) i_sva (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .dev_sel_i(dev_sel_i),
    .supply_low_i(supply_low_i), .powerfail_compare_i(powerfail_compare_i),
    .calib_or_powerfail_out_o(calib_or_powerfail_out_o),
    .backup_charge_enable_o(backup_charge_enable_o),
    .fast_charge_select_o(fast_charge_select_o));

// >>> i2c_master_model.sv
// bus master model that clocks the serial slave
`timescale 1ns/100ps
module i2c_master_model #(
    parameter int HALF_NS = 400
) (
    output logic      scl_o,
    output logic      sda_rel_o,
    input  wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
    end
    // data moves an eighth of a period after the fall so the filter never sees a false start
    task automatic put_bit(input logic b, output logic s);
        if (scl_o) #(HALF_NS / 4) scl_o = 1'b0;
        #(HALF_NS / 4) sda_rel_o = b;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        #(HALF_NS / 2) s = sda_i;
        #(HALF_NS / 2) scl_o = 1'b0;
    endtask : put_bit
    task automatic start_cond();
        #(HALF_NS / 4) sda_rel_o = 1'b1;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        #(HALF_NS / 2) sda_rel_o = 1'b0;
        #(HALF_NS / 2) scl_o = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #(HALF_NS / 4) sda_rel_o = 1'b0;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        #(HALF_NS / 2) sda_rel_o = 1'b1;
        #(HALF_NS / 2);
    endtask : stop_cond
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : write_byte
    task automatic read_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, d[i]);
        put_bit(~ack_it, s);
    endtask : read_byte
endmodule : i2c_master_model

// >>> companion_slave_bench.sv
// self-checking bench for the two-target serial slave
`timescale 1ns/100ps
module companion_slave_bench;
    import companion_pkg::*;
    localparam int unsigned HALF = 20;
    localparam logic [1:0]  SEL  = 2'b10;
    logic       mclk_i;
    logic       link_clk_i;
    logic       sys_rst_i;
    logic       supply_low_i;
    logic       cmp;
    logic [1:0] dev_sel_i;
    logic       scl_i;
    logic       sda_rel;
    wire logic  sda_i;
    logic       sda_o;
    logic       sda_oe_o;
    logic       cal_out;
    logic       chg_en;
    logic       chg_fast;
    int         n_errors;
    int         n_checks;

    // pull-up on the data line, device can only pull low
    assign sda_i = sda_rel & ~sda_oe_o;
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #7;
        forever #15 link_clk_i = ~link_clk_i;
    end

    companion_slave #(.CAL_HALF_CYCLES(HALF)) i_dut (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .dev_sel_i(dev_sel_i),
        .supply_low_i(supply_low_i), .powerfail_compare_i(cmp),
        .calib_or_powerfail_out_o(cal_out), .backup_charge_enable_o(chg_en),
        .fast_charge_select_o(chg_fast));
    i2c_master_model i_master (.scl_o(scl_i), .sda_rel_o(sda_rel), .sda_i(sda_i));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    task automatic pins(input logic c, input logic s);
        @(posedge mclk_i);
        #1 cmp = c;
        supply_low_i = s;
    endtask : pins
    function automatic logic [7:0] adr(input logic [3:0] id, input logic [1:0] s, input logic r);
        return {id, 1'b0, s, r};
    endfunction : adr
    task automatic wr_reg(input logic [7:0] ra, input logic [7:0] d);
        logic a;
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(ra, a);
        i_master.write_byte(d, a);
        i_master.stop_cond();
        check("write ack", a, 1'b1);
        repeat (40) @(posedge mclk_i);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] ra, output logic [7:0] d);
        logic a;
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(ra, a);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b1), a);
        i_master.read_byte(1'b0, d);
        i_master.stop_cond();
    endtask : rd_reg
    task automatic probe(input logic [7:0] ad, input logic exp);
        logic a;
        i_master.start_cond();
        i_master.write_byte(ad, a);
        i_master.stop_cond();
        check("address ack", a, exp);
    endtask : probe
    // cycles summed over n half periods of the shared pin, bounded
    task automatic halves(input int n, output int cyc);
        logic last;
        int c;
        cyc = 0;
        for (int k = 0; k <= n; k++) begin
            last = cal_out;
            c = 0;
            do begin
                @(posedge mclk_i);
                #1 c++;
            end while (cal_out === last && c < 2000);
            if (c >= 2000) begin
                n_errors++;
                test_done();
            end
            if (k > 0)
                cyc += c;
        end
    endtask : halves

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("charge after reset", {chg_en, chg_fast, cal_out}, 3'b001); // RESET
        pins(1'b0, 1'b0);
        repeat (8) @(posedge mclk_i);
        check("pin follows comparator", cal_out, 1'b0);
    endtask : t_reset
    task automatic t_charge();
        logic [7:0] v [4] = '{8'h0_024, 8'h0_004, 8'h0_020, 8'h0_000};
        foreach (v[i]) begin
            wr_reg(8'h0_00B, v[i]);
            check("charge enable", chg_en, v[i][VBC_BIT]);
            check("fast charge", chg_fast, v[i][FC_BIT]);
        end
    endtask : t_charge
    task automatic t_cal();
        logic [7:0] d;
        int c;
        wr_reg(8'h0_001, 8'h0_005);
        rd_reg(8'h0_001, d);
        check("locked correction", d, 8'h0_000);
        wr_reg(8'h0_000, 8'h0_004);
        halves(4, c);
        check("square half periods", c, 4 * HALF);
        wr_reg(8'h0_001, 8'h0_025);
        rd_reg(8'h0_001, d);
        check("stored correction", d, 8'h0_025);
        halves(64, c);
        halves(64, c);
        check("positive correction", c, 64 * HALF - 5);
        wr_reg(8'h0_001, 8'h0_005);
        halves(64, c);
        halves(64, c);
        check("negative correction", c, 64 * HALF + 5);
        wr_reg(8'h0_000, 8'h0_000);
        check("comparator low restored", cal_out, 1'b0);
        pins(1'b1, 1'b0);
        repeat (8) @(posedge mclk_i);
        check("comparator high restored", cal_out, 1'b1);
    endtask : t_cal
    task automatic t_addr();
        logic [7:0] d;
        logic a;
        probe(adr(ID_MEMORY, ~SEL, 1'b0), 1'b0);
        probe(adr(ID_COMPANION, SEL ^ 2'b01, 1'b0), 1'b0);
        probe(adr(4'h0_00B, SEL, 1'b0), 1'b0);
        probe(adr(ID_MEMORY, SEL, 1'b0), 1'b1);
        i_master.start_cond();
        i_master.write_byte(adr(ID_MEMORY, SEL, 1'b1), a);
        i_master.read_byte(1'b0, d);
        i_master.stop_cond();
        check("memory read", d, MEM_IDLE_DATA);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(8'h0_019, a);
        check("register past end", a, 1'b0);
        i_master.write_byte(8'h0_000, a);
        i_master.stop_cond();
        check("idle after refusal", a, 1'b0);
        wr_reg(8'h0_018, 8'h0_05A);
        rd_reg(8'h0_018, d);
        check("last register", d, 8'h0_05A);
    endtask : t_addr
    task automatic t_abort();
        logic a;
        logic s;
        wr_reg(8'h0_00B, 8'h0_004);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(8'h0_00B, a);
        i_master.stop_cond();
        i_master.write_byte(8'h0_020, a);
        i_master.stop_cond();
        check("no ack after stop", a, 1'b0);
        check("charger kept", {chg_en, chg_fast}, 2'b10);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(8'h0_00B, a);
        repeat (3) i_master.put_bit(1'b1, s);
        wr_reg(8'h0_00B, 8'h0_000);
        check("write after restart", chg_en, 1'b0);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(8'h0_00B, a);
        pins(1'b1, 1'b1);
        repeat (20) @(posedge mclk_i);
        pins(1'b1, 1'b0);
        i_master.write_byte(8'h0_024, a);
        i_master.stop_cond();
        repeat (40) @(posedge mclk_i);
        check("ack after supply drop", a, 1'b0);
        check("charger after supply drop", chg_en, 1'b0);
    endtask : t_abort
    task automatic t_read();
        logic [7:0] d;
        logic a;
        wr_reg(8'h0_00B, 8'h0_024);
        wr_reg(8'h0_00C, 8'h0_05A);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b0), a);
        i_master.write_byte(8'h0_00B, a);
        i_master.start_cond();
        i_master.write_byte(adr(ID_COMPANION, SEL, 1'b1), a);
        i_master.read_byte(1'b1, d);
        check("first read byte", d, 8'h0_024);
        i_master.read_byte(1'b0, d);
        check("second read byte", d, 8'h0_05A);
        i_master.read_byte(1'b1, d);
        i_master.stop_cond();
        check("released after nack", d, 8'h0_0FF);
    endtask : t_read

    initial begin
        #2_500_000;
        n_errors++;
        test_done();
    end
    initial begin
        n_errors = 0;
        n_checks = 0;
        sys_rst_i = 1'b1;
        supply_low_i = 1'b0;
        cmp = 1'b1;
        dev_sel_i = SEL;
        repeat (2) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        repeat (10) @(posedge mclk_i);
        t_reset();
        t_charge();
        t_cal();
        t_addr();
        t_abort();
        t_read();
        test_done();
    end
endmodule : companion_slave_bench
